// ### hdl/limits_pkg.sv
// Constants for the limits configuration register block.
// Assumes a single 10 MHz system clock and a byte-wide register port.
package limits_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] LIMITS_CONFIGURATION_ADDR = 8'h16;
  localparam int         DATA_W                    = 8;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RESTART_BIT       = 0;
  localparam int RESET_IND_BIT     = 1;
  localparam int PREWARN_LSB       = 4;
  localparam int PEAK_LSB          = 6;
  localparam logic [7:0] WRITE_MASK = 8'hf3;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] PEAK_RESET      = 2'h0;
  localparam logic [1:0] PREWARN_RESET   = 2'h0;
  localparam logic       RESTART_RESET   = 1'b0;
  localparam logic       RESET_IND_RESET = 1'b1;
  // ----------------------------------------------------------------
  // Threshold codes: degrees Celsius and tenths of an ampere
  // ----------------------------------------------------------------
  localparam logic [7:0] PREWARN_C0 = 8'h53;
  localparam logic [7:0] PREWARN_C1 = 8'h5e;
  localparam logic [7:0] PREWARN_C2 = 8'h69;
  localparam logic [7:0] PREWARN_C3 = 8'h74;
  localparam logic [7:0] PEAK_DA0   = 8'h2b;
  localparam logic [7:0] PEAK_DA1   = 8'h32;
  localparam logic [7:0] PEAK_DA2   = 8'h37;
  localparam logic [7:0] PEAK_DA3   = 8'h40;
  // ----------------------------------------------------------------
  // Thermal restart states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN      = 2'b00,
    ST_SHUTDOWN = 2'b01,
    ST_RESTART  = 2'b11,
    ST_LATCHED  = 2'b10
  } thermal_state_t;
endpackage

// ### hdl/limit_decode.sv
// Decodes the two limit fields into their analog settings.
// Assumes the codes come straight from register flip-flops.
module limit_decode
  import limits_pkg::*;
(
  input  wire logic [1:0] peak_code_i,
  input  wire logic [1:0] prewarn_code_i,
  output logic      [7:0] peak_tenths_amp_o,
  output logic      [7:0] prewarn_celsius_o
);
  // ----------------------------------------------------------------
  // Code tables
  // ----------------------------------------------------------------
  // Peak current in tenths of an ampere
  always_comb begin
    case (peak_code_i)
      2'h0:    peak_tenths_amp_o = PEAK_DA0;
      2'h1:    peak_tenths_amp_o = PEAK_DA1;
      2'h2:    peak_tenths_amp_o = PEAK_DA2;
      default: peak_tenths_amp_o = PEAK_DA3;
    endcase
  end

  // Pre-warning threshold in degrees
  always_comb begin
    case (prewarn_code_i)
      2'h0:    prewarn_celsius_o = PREWARN_C0;
      2'h1:    prewarn_celsius_o = PREWARN_C1;
      2'h2:    prewarn_celsius_o = PREWARN_C2;
      default: prewarn_celsius_o = PREWARN_C3;
    endcase
  end
endmodule

// ### hdl/limits_configuration.sv
// Limits configuration register with thermal restart control.
// Assumes a synchronous byte register port from the serial bus
// front end and a thermal shutdown level from the analog side.
// ----------------------------------------------------------------
module limits_configuration
  import limits_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  input  wire logic        clk_en_i,
  input  wire logic        reg_reset_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic        thermal_shutdown_i,
  output logic             power_enable_o,
  output logic             powerup_start_o,
  output logic [1:0]       peak_current_limit_o,
  output logic [1:0]       thermal_prewarn_threshold_o,
  output logic [7:0]       peak_tenths_amp_o,
  output logic [7:0]       prewarn_celsius_o
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]     peak;
    logic [1:0]     prewarn;
    logic           reset_ind;
    logic           restart_en;
    thermal_state_t tstate;
    logic           start_pulse;
    logic [7:0]     rdata;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic   hit;
  logic   wr_hit;
  logic [7:0] reg_image;

  assign hit    = (reg_addr_i == LIMITS_CONFIGURATION_ADDR);
  assign wr_hit = reg_wr_i && hit;

  // Register image, spare bits forced to zero
  assign reg_image = {state_reg.peak, state_reg.prewarn, 2'h0,
                      state_reg.reset_ind, state_reg.restart_en};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next             = state_reg;
    state_next.start_pulse = 1'b0;
    state_next.rdata       = hit ? reg_image : 8'h00;
    // Register reset beats a host write in the same cycle
    if (reg_reset_i) begin
      state_next.peak       = PEAK_RESET;
      state_next.prewarn    = PREWARN_RESET;
      state_next.restart_en = RESTART_RESET;
      state_next.reset_ind  = RESET_IND_RESET;
    end else if (wr_hit) begin
      // Host write; spare bits never reach the state
      state_next.peak       = reg_wdata_i[PEAK_LSB+:2];
      state_next.prewarn    = reg_wdata_i[PREWARN_LSB+:2];
      state_next.reset_ind  = reg_wdata_i[RESET_IND_BIT];
      state_next.restart_en = reg_wdata_i[RESTART_BIT];
    end
    // Thermal shutdown and restart sequencing
    case (state_reg.tstate)
      ST_RUN: begin
        if (thermal_shutdown_i) begin
          state_next.tstate = ST_SHUTDOWN;
        end
      end
      ST_SHUTDOWN: begin
        if (!state_reg.restart_en) begin
          state_next.tstate = ST_LATCHED;
        end else if (!thermal_shutdown_i) begin
          state_next.tstate = ST_RESTART;
        end
      end
      ST_RESTART: begin
        state_next.start_pulse = 1'b1;
        state_next.tstate      = ST_RUN;
      end
      ST_LATCHED: begin
        state_next.tstate = ST_LATCHED;
      end
      default: state_next.tstate = ST_LATCHED;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Async reset image; a low clock enable freezes everything
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= '{peak: PEAK_RESET, prewarn: PREWARN_RESET, reset_ind: RESET_IND_RESET,
                     restart_en: RESTART_RESET, tstate: ST_RUN, start_pulse: 1'b0,
                     rdata: 8'h00};
    end else if (clk_en_i) begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Outputs straight from the state flip-flops, except power enable, decoded from tstate
  assign reg_rdata_o                 = state_reg.rdata;
  assign power_enable_o              = (state_reg.tstate == ST_RUN);
  assign powerup_start_o             = state_reg.start_pulse;
  assign peak_current_limit_o        = state_reg.peak;
  assign thermal_prewarn_threshold_o = state_reg.prewarn;

  // Analog setting decode of the two limit fields
  limit_decode u_decode (
    .peak_code_i       (state_reg.peak),
    .prewarn_code_i    (state_reg.prewarn),
    .peak_tenths_amp_o (peak_tenths_amp_o),
    .prewarn_celsius_o (prewarn_celsius_o)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Checks pause while the async reset is low
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  // Named steps of the thermal sequence
  sequence seq_shutdown_no_restart;
    clk_en_i && state_reg.tstate == ST_SHUTDOWN && !state_reg.restart_en;
  endsequence

  sequence seq_restart_entry;
    clk_en_i && state_reg.tstate == ST_SHUTDOWN && state_reg.restart_en && !thermal_shutdown_i;
  endsequence

  // Shutdown still active with restart armed
  sequence seq_hot_with_restart;
    clk_en_i && state_reg.tstate == ST_SHUTDOWN && state_reg.restart_en && thermal_shutdown_i;
  endsequence

  // Host write taken without a register reset
  sequence seq_plain_write;
    wr_hit && clk_en_i && !reg_reset_i;
  endsequence

  AST_NO_RESTART: assert property (
    seq_shutdown_no_restart |=> (!power_enable_o && !powerup_start_o) [*3])
    else $error("Device restarted with restart disabled");

  AST_RESTART_PULSE: assert property (
    seq_restart_entry ##1 clk_en_i |=> powerup_start_o && power_enable_o)
    else $error("Restart did not start power-up");

  AST_RESTART_KEEPS: assert property (
    powerup_start_o && !$past(reg_reset_i) && !$past(wr_hit, 1) |-> $stable(reg_image))
    else $error("Restart altered register contents");

  AST_RESET_IND: assert property (
    reg_reset_i && clk_en_i |=> reg_image[RESET_IND_BIT] && reg_image[7:2] == 6'h00)
    else $error("Register reset did not set indicator");

  AST_IND_CLEAR: assert property (
    wr_hit && clk_en_i && !reg_reset_i && !reg_wdata_i[RESET_IND_BIT] |=> !reg_image[RESET_IND_BIT])
    else $error("Indicator clear write ignored");

  AST_PREWARN: assert property (
    wr_hit && clk_en_i && !reg_reset_i |=> prewarn_celsius_o ==
      (($past(reg_wdata_i[5:4]) == 2'h0) ? PREWARN_C0 : ($past(reg_wdata_i[5:4]) == 2'h1) ? PREWARN_C1 :
       ($past(reg_wdata_i[5:4]) == 2'h2) ? PREWARN_C2 : PREWARN_C3))
    else $error("Pre-warning threshold mismatch");

  AST_PEAK: assert property (
    wr_hit && clk_en_i && !reg_reset_i |=> peak_current_limit_o == $past(reg_wdata_i[7:6]))
    else $error("Peak current field mismatch");

  AST_SPARE: assert property (
    reg_rdata_o[3:2] == 2'h0 && (reg_rdata_o & ~WRITE_MASK) == 8'h00)
    else $error("Spare bits read non-zero");

  // Latched shutdown never lets power back on
  AST_LATCH_HOLD: assert property (
    state_reg.tstate == ST_LATCHED |=> state_reg.tstate == ST_LATCHED && !power_enable_o)
    else $error("Latched shutdown was left");

  // Armed restart waits for the shutdown to clear
  AST_RESTART_WAIT: assert property (
    seq_hot_with_restart |=> state_reg.tstate == ST_SHUTDOWN && !power_enable_o)
    else $error("Restart began while still shut down");

  // Power-up start lasts a single enabled cycle
  AST_PULSE_ONE: assert property (
    powerup_start_o && clk_en_i |=> !powerup_start_o)
    else $error("Power-up start longer than one cycle");

  // Register reset loads the full reset image, write or not
  AST_RESET_WINS: assert property (
    reg_reset_i && clk_en_i |=> reg_image == {PEAK_RESET, PREWARN_RESET, 2'h0, RESET_IND_RESET, RESTART_RESET})
    else $error("Register reset image wrong");

  // A write lands with the spare bits dropped
  AST_WRITE_IMAGE: assert property (
    seq_plain_write |=> reg_image == ($past(reg_wdata_i) & WRITE_MASK))
    else $error("Written image wrong");

  // Read data shows the image of the previous cycle
  AST_READ_IMAGE: assert property (
    clk_en_i && hit |=> reg_rdata_o == $past(reg_image))
    else $error("Read data differs from image");
endmodule

// ### testbench/host_model.sv
// Host software model driving the byte register port.
// Assumes the bench clock; requests change 1 ns after a rising edge.
module host_model
  import limits_pkg::*;
(
  input  wire logic       clk_sys_i,
  output logic      [7:0] reg_addr_o,
  output logic            reg_wr_o,
  output logic      [7:0] reg_wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus at time zero
  initial begin
    reg_addr_o = 8'h16;
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'h00;
  end
  // Point reads at an address
  task automatic set_addr(input logic [7:0] a);
    reg_addr_o = a;
  endtask
  // One write, held over one rising edge
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    reg_addr_o = a;
    reg_wr_o = 1'b1;
    reg_wdata_o = d;
    @(posedge clk_sys_i);
    #1;
    reg_wr_o = 1'b0;
    reg_wdata_o = ~d; // Released data flips
    reg_addr_o = 8'h16;
  endtask
endmodule

// ### testbench/limits_configuration_tb.sv
// Self-checking bench for the limits configuration register.
// Assumes a 100 ns clock and inputs driven 1 ns after rising edges.
module limits_configuration_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import limits_pkg::*;
  logic       clk_sys_i = 1'b0;
  logic       resetn_i, clk_en_i, reg_reset_i, reg_wr_i, thermal_shutdown_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, peak_tenths_amp_o, prewarn_celsius_o;
  logic       power_enable_o, powerup_start_o;
  logic [1:0] peak_current_limit_o, thermal_prewarn_threshold_o;
  int         num_errors = 0, check_count = 0, img, hits;
  int         amp_t[4] = '{43, 50, 55, 64};
  int         cel_t[4] = '{83, 94, 105, 116};
  logic [31:0] seed = 32'h6a51e077;
  logic [7:0]  a;
  always #50 clk_sys_i = ~clk_sys_i;
  host_model i_host (.clk_sys_i, .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i));
  limits_configuration i_dut (.clk_sys_i, .resetn_i, .clk_en_i, .reg_reset_i, .reg_addr_i, .reg_wr_i,
    .reg_wdata_i, .reg_rdata_o, .thermal_shutdown_i, .power_enable_o, .powerup_start_o,
    .peak_current_limit_o, .thermal_prewarn_threshold_o, .peak_tenths_amp_o, .prewarn_celsius_o);
  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic results;
    if (num_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Xorshift source
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  // Read back image, fields and decoded settings
  task automatic rd;
    @(posedge clk_sys_i);
    #1;
    chk(reg_rdata_o, 8'(img));
    chk({6'h0, peak_current_limit_o}, 8'(img >> 6));
    chk(peak_tenths_amp_o, 8'(amp_t[(img >> 6) & 3]));
    chk({6'h0, thermal_prewarn_threshold_o}, 8'((img >> 4) & 3));
    chk(prewarn_celsius_o, 8'(cel_t[(img >> 4) & 3]));
  endtask
  // Host write with model update; only the mapped address counts
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    i_host.write_reg(ad, d);
    if (ad == 8'h16) img = d & 8'hf3;
  endtask
  // Thermal event: shutdown then release, count start pulses
  task automatic trip;
    thermal_shutdown_i = 1'b1;
    @(posedge clk_sys_i);
    #1;
    chk({7'h0, power_enable_o}, 8'h00);
    @(posedge clk_sys_i);
    #1;
    chk({7'h0, power_enable_o}, 8'h00);
    thermal_shutdown_i = 1'b0;
    hits = 0;
    repeat (6) begin
      @(posedge clk_sys_i);
      #1;
      if (powerup_start_o === 1'b1) hits++;
    end
  endtask
  initial begin
    resetn_i = 1'b0;
    clk_en_i = 1'b1;
    reg_reset_i = 1'b0;
    thermal_shutdown_i = 1'b0;
    img = 8'h02;
    repeat (10) @(posedge clk_sys_i);
    #1;
    resetn_i = 1'b1;
    rd;
    wr(8'h16, 8'h00);
    rd;
    // Every code of both fields, spare bits set
    for (int c = 0; c < 16; c++) begin
      wr(8'h16, {c[3:0], 4'hc});
      rd;
    end
    // Random writes, some to unmapped places
    repeat (24) begin
      seed = xs(seed);
      a = seed[9] ? 8'h16 : seed[23:16];
      wr(a, seed[7:0]);
      rd;
    end
    i_host.set_addr(8'h21);
    @(posedge clk_sys_i);
    #1;
    chk(reg_rdata_o, 8'h00);
    i_host.set_addr(8'h16);
    // Frozen clock enable ignores a write
    clk_en_i = 1'b0;
    i_host.write_reg(8'h16, 8'hc0);
    clk_en_i = 1'b1;
    rd;
    reg_reset_i = 1'b1;
    i_host.write_reg(8'h16, 8'hc1); // Reset beats this write
    reg_reset_i = 1'b0;
    img = 8'h02;
    rd;
    wr(8'h16, 8'hb1);
    trip;
    chk(8'(hits), 8'h01);
    chk({7'h0, power_enable_o}, 8'h01);
    rd;
    wr(8'h16, 8'h70);
    trip;
    chk(8'(hits), 8'h00);
    chk({7'h0, power_enable_o}, 8'h00);
    // Only a full reset leaves the latched shutdown
    resetn_i = 1'b0;
    @(posedge clk_sys_i);
    #1;
    resetn_i = 1'b1;
    chk({7'h0, power_enable_o}, 8'h01);
    img = 8'h02;
    rd;
    results;
  end
endmodule
